// ---- bench/serial_ctrl_model.sv ----
// Controller model driving serial clock, data and load strobe.
// Runs on its own time base, unrelated to the port's system clock.
`timescale 1ns/1ps
module serial_ctrl_model
(
    output logic sclk,
    output logic sdata,
    output logic strobe
);
    initial
    begin
        sclk = 1'b0;
        sdata = 1'b0;
        strobe = 1'b0;
    end
    // Extra leading bits are junk; serial clock idles low between frames
    task automatic send_word(input logic [21:0] w, input int n, input int k);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata = (i > 21) ? ~w[i % 22] : w[i];
            #(62.5 * k) sclk = 1'b1;
            #(62.5 * k) sclk = 1'b0;
        end
        // No stale level left on the released data line
        sdata = ~sdata;
        #(62.5 * k) strobe = 1'b1;
        #250 strobe = 1'b0;
        #250;
    endtask
endmodule

// ---- bench/synth_port_chk_chk.sv ----
// Checker for the latched fields of the serial programming port.
// Bound to the port's top module; sees its pins only.
`timescale 1ns/1ps
module synth_port_chk
(
    input wire REF_CLK,
    input wire RESETN,
    input wire LOAD_STROBE,
    input wire [14:0] SECONDARY_REF_COUNT,
    input wire [4:0] SECONDARY_SWALLOW_COUNT,
    input wire [14:0] PRIMARY_REF_COUNT,
    input wire [12:0] PRIMARY_PROGRAM_COUNT,
    input wire [1:0] LAST_LOAD_ADDRESS
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);
    // Eight idle cycles leave no strobe edge in the sync pipeline
    sequence quiet;
        !LOAD_STROBE [*8];
    endsequence
    chk_sec_ref_hold: assert property
        (quiet |=> $stable(SECONDARY_REF_COUNT))
        else $error("secondary reference changed without load");
    chk_sec_fb_hold: assert property
        (quiet |=> $stable(SECONDARY_SWALLOW_COUNT))
        else $error("secondary feedback changed without load");
    chk_pri_ref_hold: assert property
        (quiet |=> $stable(PRIMARY_REF_COUNT))
        else $error("primary reference changed without load");
    chk_pri_fb_hold: assert property
        (quiet |=> $stable(PRIMARY_PROGRAM_COUNT))
        else $error("primary feedback changed without load");
    chk_addr_cause: assert property
        ($changed(LAST_LOAD_ADDRESS) |-> $past(LOAD_STROBE, 2))
        else $error("address changed without strobe");
    chk_sec_ref_addr: assert property
        ($changed(SECONDARY_REF_COUNT) |-> LAST_LOAD_ADDRESS == 2'h0)
        else $error("secondary reference loaded at wrong address");
    chk_sec_fb_addr: assert property
        ($changed(SECONDARY_SWALLOW_COUNT) |-> LAST_LOAD_ADDRESS == 2'h1)
        else $error("secondary feedback loaded at wrong address");
    chk_pri_ref_addr: assert property
        ($changed(PRIMARY_REF_COUNT) |-> LAST_LOAD_ADDRESS == 2'h2)
        else $error("primary reference loaded at wrong address");
    chk_pri_fb_addr: assert property
        ($changed(PRIMARY_PROGRAM_COUNT) |-> LAST_LOAD_ADDRESS == 2'h3)
        else $error("primary feedback loaded at wrong address");
    cover property ($rose(LOAD_STROBE));
    cover property ($changed(PRIMARY_REF_COUNT));
    cover property (LAST_LOAD_ADDRESS == 2'h3);
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the serial programming port.
// Drives the pins through the controller model; checks latched fields.
`timescale 1ns/1ps
module testbench;
    logic REF_CLK;
    logic RESETN;
    wire SERIAL_CLK, SERIAL_DATA, LOAD_STROBE;
    wire [14:0] SECONDARY_REF_COUNT, PRIMARY_REF_COUNT;
    wire [4:0] SECONDARY_SWALLOW_COUNT, PRIMARY_SWALLOW_COUNT;
    wire [12:0] SECONDARY_PROGRAM_COUNT, PRIMARY_PROGRAM_COUNT;
    wire [1:0] SECONDARY_MULTIFUNCTION_OUTPUT_SELECT, LAST_LOAD_ADDRESS;
    wire [1:0] PRIMARY_MULTIFUNCTION_OUTPUT_SELECT;
    wire SECONDARY_DETECTOR_POLARITY, SECONDARY_PUMP_HIGH_CURRENT;
    wire SECONDARY_PUMP_FLOAT, SECONDARY_PRESCALER_SELECT;
    wire SECONDARY_POWERDOWN, PRIMARY_POWERDOWN, PRIMARY_PRESCALER_SELECT;
    wire PRIMARY_DETECTOR_POLARITY, PRIMARY_PUMP_HIGH_CURRENT;
    wire PRIMARY_PUMP_FLOAT;
    wire [19:0] got [4];
    logic [19:0] exp_q [4];
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    assign got[0] = {SECONDARY_MULTIFUNCTION_OUTPUT_SELECT,
        SECONDARY_PUMP_FLOAT,
        SECONDARY_PUMP_HIGH_CURRENT, SECONDARY_DETECTOR_POLARITY,
        SECONDARY_REF_COUNT};
    assign got[1] = {SECONDARY_POWERDOWN, SECONDARY_PRESCALER_SELECT,
        SECONDARY_PROGRAM_COUNT, SECONDARY_SWALLOW_COUNT};
    assign got[2] = {PRIMARY_MULTIFUNCTION_OUTPUT_SELECT, PRIMARY_PUMP_FLOAT,
        PRIMARY_PUMP_HIGH_CURRENT, PRIMARY_DETECTOR_POLARITY,
        PRIMARY_REF_COUNT};
    assign got[3] = {PRIMARY_POWERDOWN, PRIMARY_PRESCALER_SELECT,
        PRIMARY_PROGRAM_COUNT, PRIMARY_SWALLOW_COUNT};
    synth_serial_program_port u_synth_serial_program_port (.*);
    serial_ctrl_model u_serial_ctrl_model
    (
        .sclk(SERIAL_CLK),
        .sdata(SERIAL_DATA),
        .strobe(LOAD_STROBE)
    );
    task automatic complete_run();
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_val(input string name, input logic [19:0] seen,
        input logic [19:0] want);
        check_count++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, want, seen);
        end
    endtask
    // Every latch is compared, so an unaddressed one that moves is caught
    task automatic load(input logic [1:0] a, input logic [19:0] d,
        input int n, input int k);
        u_serial_ctrl_model.send_word({d, a}, n, k);
        exp_q[a] = d;
        for (int i = 0; i < 4; i++)
            check_val("latch", got[i], exp_q[i]);
        check_val("last_addr", {18'h00000, LAST_LOAD_ADDRESS},
            {18'h00000, a});
    endtask
    initial
    begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        RESETN = 1'b0;
        exp_q = '{4{20'h00000}};
        repeat (20) @(posedge REF_CLK);
        #1 RESETN = 1'b1;
        repeat (10) @(posedge REF_CLK);
        check_val("reset", got[0] | got[1] | got[2] | got[3],
            20'h00000);
        // Reference count of 2 is the smallest legal ratio
        load(2'h0, 20'hA8002, 22, 1);
        load(2'h1, 20'h5FFE1, 22, 1);
        load(2'h2, 20'h7FFFF, 22, 1);
        load(2'h3, 20'hC0001, 22, 1);
        load(2'h0, 20'h57FFF, 30, 3);
        load(2'h3, 20'h3FFFE, 22, 1);
        complete_run();
    end
endmodule
bind synth_serial_program_port synth_port_chk u_synth_port_chk (.*);

// ---- include/synth_prog_regs.vh ----
// Constants for the synthesizer serial programming port.
// Included by the port only; the edge detector does not use it; definitions only.
`ifndef SYNTH_PROG_REGS_VH
`define SYNTH_PROG_REGS_VH

`define WORD_BITS 22
`define DATA_BITS 20
`define DATA_MSB 21
`define DATA_LSB 2
`define ADDR_MSB 1
`define ADDR_LSB 0

`define ADDR_SEC_REF 2'h0
`define ADDR_SEC_FB 2'h1
`define ADDR_PRI_REF 2'h2
`define ADDR_PRI_FB 2'h3

// Field positions inside the 20-bit latched data field
`define REF_COUNT_MSB 14
`define REF_COUNT_LSB 0
`define REF_POL_BIT 15
`define REF_HIGHCUR_BIT 16
`define REF_FLOAT_BIT 17
`define REF_MUXSEL_MSB 19
`define REF_MUXSEL_LSB 18
`define FB_SWALLOW_MSB 4
`define FB_SWALLOW_LSB 0
`define FB_PROGRAM_MSB 17
`define FB_PROGRAM_LSB 5
`define FB_PRESCALE_BIT 18
`define FB_POWERDOWN_BIT 19

`define LATCH_RESET 20'h00000

`endif

// ---- src/pin_edge_sync.v ----
// Three-stage synchroniser with rising edge detection for one pin.
// Assumes the pin is asynchronous to clk; rst_n is already synchronised.
`timescale 1ns/1ps
module pin_edge_sync
(
    input wire clk,
    input wire rst_n,
    input wire pin,
    output wire level,
    output wire rise
);
    reg meta_reg;
    reg sync_a_reg;
    reg sync_b_reg;
    reg level_reg;

    // A change counts only once the second and third stages agree
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 1'b0;
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin;
            sync_a_reg <= meta_reg;
            sync_b_reg <= sync_a_reg;
            if (sync_a_reg == sync_b_reg)
                level_reg <= sync_b_reg;
        end
    end

    assign level = level_reg;
    assign rise = (sync_a_reg == sync_b_reg) & sync_b_reg & ~level_reg;
endmodule

// ---- src/synth_serial_program_port.v ----
// Serial programming port: 22-bit shift register and four 20-bit latches.
// Serial clock, data and load strobe are pins sampled by REF_CLK, which
// must run well above the serial clock (at least 8x is comfortable).
`timescale 1ns/1ps
`include "synth_prog_regs.vh"

// Behaviour
// - Bits gather in 22-bit holding shift register
// - Bits 21..2 data, bits 1..0 address
// - One bit per rising serial clock, MSB first
// - Load strobe rise copies data to addressed latch
// - Codes 00,01,10,11 pick SR,SF,PR,PF latches
// - Secondary reference count in word bits 16..2
// - Secondary reference upper bits hold mode settings
// - Reference count is plain binary, LSB bit 2
// - Primary reference word has same layout
// - Secondary feedback: powerdown, prescaler, program, swallow
// - Primary feedback uses same layout
// - Port works during any powerdown
module synth_serial_program_port
(
    input wire REF_CLK,
    input wire RESETN,
    input wire SERIAL_CLK,
    input wire SERIAL_DATA,
    input wire LOAD_STROBE,
    output wire [14:0] SECONDARY_REF_COUNT,
    output wire SECONDARY_DETECTOR_POLARITY,
    output wire SECONDARY_PUMP_HIGH_CURRENT,
    output wire SECONDARY_PUMP_FLOAT,
    output wire [1:0] SECONDARY_MULTIFUNCTION_OUTPUT_SELECT,
    output wire [4:0] SECONDARY_SWALLOW_COUNT,
    output wire [12:0] SECONDARY_PROGRAM_COUNT,
    output wire SECONDARY_PRESCALER_SELECT,
    output wire SECONDARY_POWERDOWN,
    output wire [14:0] PRIMARY_REF_COUNT,
    output wire PRIMARY_DETECTOR_POLARITY,
    output wire PRIMARY_PUMP_HIGH_CURRENT,
    output wire PRIMARY_PUMP_FLOAT,
    output wire [1:0] PRIMARY_MULTIFUNCTION_OUTPUT_SELECT,
    output wire [4:0] PRIMARY_SWALLOW_COUNT,
    output wire [12:0] PRIMARY_PROGRAM_COUNT,
    output wire PRIMARY_PRESCALER_SELECT,
    output wire PRIMARY_POWERDOWN,
    output wire [1:0] LAST_LOAD_ADDRESS
);
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_n;

    wire sclk_rise;
    wire data_level;
    wire load_rise;

    reg [`WORD_BITS-1:0] shift_reg;
    reg [`WORD_BITS-1:0] shift_next;
    reg [`DATA_BITS-1:0] sec_ref_reg;
    reg [`DATA_BITS-1:0] sec_fb_reg;
    reg [`DATA_BITS-1:0] pri_ref_reg;
    reg [`DATA_BITS-1:0] pri_fb_reg;
    reg [1:0] last_addr_reg;

    wire [`DATA_BITS-1:0] word_data;
    wire [1:0] word_addr;

    // Reset is asserted at once and released through two flip-flops
    always @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    pin_edge_sync sclk_sync
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .pin(SERIAL_CLK),
        .level(),
        .rise(sclk_rise)
    );

    // Data is taken from the level register after the same three stages, so the shift sees it one cycle behind the clock
    pin_edge_sync data_sync
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .pin(SERIAL_DATA),
        .level(data_level),
        .rise()
    );

    pin_edge_sync load_sync
    (
        .clk(REF_CLK),
        .rst_n(rst_n),
        .pin(LOAD_STROBE),
        .level(),
        .rise(load_rise)
    );

    // Shifting toward the MSB keeps just the most recent 22 bits
    always @*
    begin
        shift_next = shift_reg;
        if (sclk_rise)
            shift_next = {shift_reg[`WORD_BITS-2:0], data_level};
    end

    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= {`WORD_BITS{1'b0}};
        else
            shift_reg <= shift_next;
    end

    assign word_data = shift_reg[`DATA_MSB:`DATA_LSB];
    assign word_addr = shift_reg[`ADDR_MSB:`ADDR_LSB];

    // Latches change only on a load strobe rise; power-down bits do not
    // gate this path, so programming works in every power state.
    always @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sec_ref_reg <= `LATCH_RESET;
            sec_fb_reg <= `LATCH_RESET;
            pri_ref_reg <= `LATCH_RESET;
            pri_fb_reg <= `LATCH_RESET;
            last_addr_reg <= 2'h0;
        end
        else if (load_rise)
        begin
            last_addr_reg <= word_addr;
            case (word_addr)
                `ADDR_SEC_REF: sec_ref_reg <= word_data;
                `ADDR_SEC_FB: sec_fb_reg <= word_data;
                `ADDR_PRI_REF: pri_ref_reg <= word_data;
                `ADDR_PRI_FB: pri_fb_reg <= word_data;
                default: last_addr_reg <= word_addr;
            endcase
        end
    end

    // Ratios below two are passed through unchecked; the controller owns it
    assign SECONDARY_REF_COUNT =
        sec_ref_reg[`REF_COUNT_MSB:`REF_COUNT_LSB];
    assign SECONDARY_DETECTOR_POLARITY = sec_ref_reg[`REF_POL_BIT];
    assign SECONDARY_PUMP_HIGH_CURRENT =
        sec_ref_reg[`REF_HIGHCUR_BIT];
    assign SECONDARY_PUMP_FLOAT = sec_ref_reg[`REF_FLOAT_BIT];
    assign SECONDARY_MULTIFUNCTION_OUTPUT_SELECT =
        sec_ref_reg[`REF_MUXSEL_MSB:`REF_MUXSEL_LSB];

    assign PRIMARY_REF_COUNT =
        pri_ref_reg[`REF_COUNT_MSB:`REF_COUNT_LSB];
    assign PRIMARY_DETECTOR_POLARITY = pri_ref_reg[`REF_POL_BIT];
    assign PRIMARY_PUMP_HIGH_CURRENT = pri_ref_reg[`REF_HIGHCUR_BIT];
    assign PRIMARY_PUMP_FLOAT = pri_ref_reg[`REF_FLOAT_BIT];
    assign PRIMARY_MULTIFUNCTION_OUTPUT_SELECT =
        pri_ref_reg[`REF_MUXSEL_MSB:`REF_MUXSEL_LSB];

    assign SECONDARY_SWALLOW_COUNT =
        sec_fb_reg[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];
    assign SECONDARY_PROGRAM_COUNT =
        sec_fb_reg[`FB_PROGRAM_MSB:`FB_PROGRAM_LSB];
    assign SECONDARY_PRESCALER_SELECT = sec_fb_reg[`FB_PRESCALE_BIT];
    assign SECONDARY_POWERDOWN = sec_fb_reg[`FB_POWERDOWN_BIT];

    assign PRIMARY_SWALLOW_COUNT =
        pri_fb_reg[`FB_SWALLOW_MSB:`FB_SWALLOW_LSB];
    assign PRIMARY_PROGRAM_COUNT =
        pri_fb_reg[`FB_PROGRAM_MSB:`FB_PROGRAM_LSB];
    assign PRIMARY_PRESCALER_SELECT = pri_fb_reg[`FB_PRESCALE_BIT];
    assign PRIMARY_POWERDOWN = pri_fb_reg[`FB_POWERDOWN_BIT];

    assign LAST_LOAD_ADDRESS = last_addr_reg;
endmodule
